// *** aid_pkg.sv ***
// Shared constants, command codes and identification memory contents for the adaptor-ID link
package aid_pkg;
  // Fixed seven-bit bus address, not configurable
  localparam logic [6:0] SLAVE_ADDR = 7'h40;
  localparam logic [7:0] LAST_LOC = 8'h10;
  localparam logic [7:0] EOT_CODE = 8'h04;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Operating mode encodings on the mode pins; the unused code acts as lowest power
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_LP_DDC = 2'h1;
  localparam logic [1:0] MODE_LOWEST = 2'h2;

  // Bus timing: standard mode, 100 kbps
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_MIN = 8;

  // Controller register map and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CMD_LSB = 8;
  localparam int CMD_NACK_BIT = 11;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int STAT_RX_LSB = 8;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h4;

  // Read-only identification memory: phrase, end-of-transmission, then fill
  function automatic logic [7:0] aid_id_byte(input logic [7:0] loc);
    case (loc)
      8'h00: aid_id_byte = 8'h44;
      8'h01: aid_id_byte = 8'h50;
      8'h02: aid_id_byte = 8'h2d;
      8'h03: aid_id_byte = 8'h48;
      8'h04: aid_id_byte = 8'h44;
      8'h05: aid_id_byte = 8'h4d;
      8'h06: aid_id_byte = 8'h49;
      8'h07: aid_id_byte = 8'h20;
      8'h08: aid_id_byte = 8'h41;
      8'h09: aid_id_byte = 8'h44;
      8'h0a: aid_id_byte = 8'h41;
      8'h0b: aid_id_byte = 8'h50;
      8'h0c: aid_id_byte = 8'h54;
      8'h0d: aid_id_byte = 8'h4f;
      8'h0e: aid_id_byte = 8'h52;
      8'h0f: aid_id_byte = EOT_CODE;
      default: aid_id_byte = FILL_BYTE;
    endcase
  endfunction
endpackage

// *** aid_if.sv ***
// Two-wire bus between the source-side controller and the adaptor-ID slave
`timescale 1ns/100ps
interface aid_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: a low from any enabled driver wins over a high
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                  input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// *** aid_master.sv ***
// Source-side bus controller driven by software through a small register port
`timescale 1ns/100ps
module aid_master #(
  parameter int QTR_CYCLES = aid_pkg::QTR_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  aid_if.master bus,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BYTE} aid_mst_state_t;

  if (QTR_CYCLES < aid_pkg::QTR_MIN || QTR_CYCLES > 65535) begin : g_chk
    $error("QTR_CYCLES out of range");
  end

  aid_mst_state_t state_q;
  logic [15:0] tick_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic is_read_q;
  logic nack_q;
  logic ack_q;
  logic busy_q;
  logic [1:0] sda_s_q;
  logic tick;
  logic cmd_wr;
  logic [2:0] cmd_code;

  assign tick = (tick_q == 16'(QTR_CYCLES - 1));
  assign cmd_wr = reg_wr_i && (reg_addr_i == aid_pkg::REG_CMD) && !busy_q;
  assign cmd_code = reg_wdata_i[aid_pkg::CMD_LSB +: 3];

  // Bus level arrives from the pin, so it is synchronised before use
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_s_q <= 2'h0;
    end else begin
      sda_s_q <= {sda_s_q[0], bus.sda};
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_q <= 16'h0;
    end else if (cmd_wr || tick || !busy_q) begin
      tick_q <= 16'h0;
    end else begin
      tick_q <= tick_q + 16'h1;
    end
  end

  // Each bit and each condition takes four quarter phases of the bus clock
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= M_IDLE;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h0;
      rx_q <= 8'h0;
      is_read_q <= 1'b0;
      nack_q <= 1'b0;
      ack_q <= 1'b0;
      busy_q <= 1'b0;
      bus.m_scl_o <= 1'b0;
      bus.m_scl_oe <= 1'b0;
      bus.m_sda_o <= 1'b0;
      bus.m_sda_oe <= 1'b0;
    end else if (cmd_wr) begin
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= reg_wdata_i[7:0];
      nack_q <= reg_wdata_i[aid_pkg::CMD_NACK_BIT];
      is_read_q <= (cmd_code == aid_pkg::CMD_READ);
      busy_q <= 1'b1;
      case (cmd_code)
        aid_pkg::CMD_START: state_q <= M_START;
        aid_pkg::CMD_STOP: state_q <= M_STOP;
        aid_pkg::CMD_WRITE, aid_pkg::CMD_READ: state_q <= M_BYTE;
        default: busy_q <= 1'b0;
      endcase
    end else if (tick && busy_q) begin
      phase_q <= phase_q + 2'h1;
      case (state_q)
        M_START: begin
          case (phase_q)
            2'h0: bus.m_sda_oe <= 1'b0;
            2'h1: bus.m_scl_oe <= 1'b0;
            2'h2: bus.m_sda_oe <= 1'b1;
            default: begin
              bus.m_scl_oe <= 1'b1;
              busy_q <= 1'b0;
              state_q <= M_IDLE;
            end
          endcase
        end
        M_STOP: begin
          case (phase_q)
            2'h0: bus.m_sda_oe <= 1'b1;
            2'h1: bus.m_scl_oe <= 1'b0;
            2'h2: bus.m_sda_oe <= 1'b0;
            default: begin
              busy_q <= 1'b0;
              state_q <= M_IDLE;
            end
          endcase
        end
        M_BYTE: begin
          case (phase_q)
            2'h0: begin
              // Data changes only with the clock low
              if (bit_q < aid_pkg::BYTE_BITS) begin
                bus.m_sda_oe <= !is_read_q && !tx_q[7];
              end else begin
                bus.m_sda_oe <= is_read_q && !nack_q;
              end
            end
            2'h1: bus.m_scl_oe <= 1'b0;
            2'h2: begin
              if (bit_q < aid_pkg::BYTE_BITS) begin
                rx_q <= {rx_q[6:0], sda_s_q[1]};
              end else begin
                ack_q <= !sda_s_q[1];
              end
            end
            default: begin
              bus.m_scl_oe <= 1'b1;
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              if (bit_q == aid_pkg::BYTE_BITS) begin
                busy_q <= 1'b0;
                state_q <= M_IDLE;
              end
            end
          endcase
        end
        default: state_q <= M_IDLE;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i && reg_addr_i == aid_pkg::REG_STAT) begin
      reg_rdata_o <= 32'h0;
      reg_rdata_o[aid_pkg::STAT_BUSY_BIT] <= busy_q;
      reg_rdata_o[aid_pkg::STAT_ACK_BIT] <= ack_q;
      reg_rdata_o[aid_pkg::STAT_RX_LSB +: 8] <= rx_q;
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end
endmodule

// *** aid_slave.sv ***
// Adaptor-side control: hot-plug forwarding, mode outputs and the ID memory bus slave
`timescale 1ns/100ps
module aid_slave (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  aid_if.slave bus,
  input wire logic sink_hotplug_in_i,
  input wire logic hotplug_invert_strap_i,
  input wire logic id_enable_strap_i,
  input wire logic [1:0] mode_i,
  output logic source_hotplug_out_o,
  output logic main_link_en_o,
  output logic ddc_active_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_WAIT} aid_slv_state_t;

  aid_slv_state_t state_q;
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_d_q;
  logic sda_d_q;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [3:0] cnt_q;
  logic ack_ph_q;
  logic first_q;
  logic rd_xfer_q;
  logic [7:0] ptr_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] cur_byte;
  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sink_lvl;
  logic inv_lvl;
  logic en_lvl;
  logic [1:0] mode_lvl;
  logic slave_on;

  // Pins and bus wires are asynchronous: two flops, then a third for edges
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      pin_s1_q <= 5'h0;
      pin_s2_q <= 5'h0;
    end else begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
      pin_s1_q <= {sink_hotplug_in_i, hotplug_invert_strap_i, id_enable_strap_i, mode_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign scl_now = scl_s_q[1];
  assign sda_now = sda_s_q[1];
  assign scl_rise = scl_now && !scl_d_q;
  assign scl_fall = !scl_now && scl_d_q;
  assign start_det = scl_now && scl_d_q && sda_d_q && !sda_now;
  assign stop_det = scl_now && scl_d_q && !sda_d_q && sda_now;
  assign sink_lvl = pin_s2_q[4];
  assign inv_lvl = pin_s2_q[3];
  assign en_lvl = pin_s2_q[2];
  assign mode_lvl = pin_s2_q[1:0];
  assign slave_on = en_lvl && (mode_lvl == aid_pkg::MODE_ACTIVE ||
                               mode_lvl == aid_pkg::MODE_LP_DDC);
  assign cur_byte = aid_pkg::aid_id_byte(ptr_q);

  // Hot-plug path has no mode gating at all
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      source_hotplug_out_o <= 1'b0;
    end else begin
      source_hotplug_out_o <= sink_lvl ^ inv_lvl;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_link_en_o <= 1'b0;
      ddc_active_o <= 1'b0;
    end else begin
      main_link_en_o <= (mode_lvl == aid_pkg::MODE_ACTIVE);
      ddc_active_o <= (mode_lvl == aid_pkg::MODE_ACTIVE) ||
                      (mode_lvl == aid_pkg::MODE_LP_DDC);
    end
  end

  // Data output only ever pulls low; the clock wire is never driven
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus.s_sda_o <= 1'b0;
    end else begin
      bus.s_sda_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      first_q <= 1'b0;
      rd_xfer_q <= 1'b0;
      ptr_q <= aid_pkg::PTR_RST;
      shift_q <= 8'h0;
      tx_q <= 8'h0;
      bus.s_sda_oe <= 1'b0;
    end else if (!slave_on) begin
      // Disabled or lowest power: drop any transfer and keep off the bus
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      bus.s_sda_oe <= 1'b0;
    end else if (start_det) begin
      // Repeated start restarts address reception from any state
      state_q <= ST_ADDR;
      cnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      bus.s_sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      rd_xfer_q <= 1'b0;
      bus.s_sda_oe <= 1'b0;
      // Lets a read without sub-address write start at location zero
      if (rd_xfer_q) begin
        ptr_q <= aid_pkg::PTR_RST;
      end
    end else begin
      case (state_q)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise && cnt_q < aid_pkg::BYTE_BITS) begin
            shift_q <= {shift_q[6:0], sda_now};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == aid_pkg::BYTE_BITS && !ack_ph_q) begin
            if (state_q == ST_WRITE || shift_q[7:1] == aid_pkg::SLAVE_ADDR) begin
              ack_ph_q <= 1'b1;
              bus.s_sda_oe <= 1'b1;
              if (state_q == ST_WRITE && first_q) begin
                ptr_q <= shift_q;
              end
            end else begin
              state_q <= ST_WAIT;
            end
          end else if (scl_fall && ack_ph_q) begin
            ack_ph_q <= 1'b0;
            cnt_q <= 4'h0;
            first_q <= (state_q == ST_ADDR);
            if (state_q == ST_ADDR && shift_q[0]) begin
              state_q <= ST_READ;
              rd_xfer_q <= 1'b1;
              tx_q <= {cur_byte[6:0], 1'b0};
              bus.s_sda_oe <= !cur_byte[7];
            end else begin
              state_q <= ST_WRITE;
              bus.s_sda_oe <= 1'b0;
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            if (cnt_q < aid_pkg::BYTE_BITS) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (!sda_now) begin
              ack_ph_q <= 1'b1;
              if (ptr_q < aid_pkg::LAST_LOC) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end else begin
              state_q <= ST_WAIT;
            end
          end else if (scl_fall) begin
            if (cnt_q < aid_pkg::BYTE_BITS) begin
              bus.s_sda_oe <= !tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end else if (ack_ph_q) begin
              ack_ph_q <= 1'b0;
              cnt_q <= 4'h0;
              tx_q <= {cur_byte[6:0], 1'b0};
              bus.s_sda_oe <= !cur_byte[7];
            end else begin
              bus.s_sda_oe <= 1'b0;
            end
          end
        end
        ST_WAIT, ST_IDLE: begin
          bus.s_sda_oe <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          bus.s_sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** aid_properties.sv ***
// Bus-level checks on the two-wire link between the controller and the ID slave
`timescale 1ns/100ps
module aid_properties (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] addr_q;
  wire logic rise = scl && !scl_q;
  wire logic start_ev = scl && scl_q && sda_q && !sda;

  // Bit counter restarted by every start; the first unit is the address
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        cnt_q <= 4'h0;
        first_q <= 1'b1;
      end else if (rise) begin
        if (cnt_q == 4'h8) begin
          cnt_q <= 4'h0;
          first_q <= 1'b0;
          if (first_q) begin
            addr_q <= sh_q;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
          sh_q <= {sh_q[6:0], sda};
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_start;
    start_ev;
  endsequence
  sequence s_stop;
    scl && scl_q && !sda_q && sda;
  endsequence
  sequence s_ninth;
    rise && cnt_q == 4'h8;
  endsequence

  property p_open_drain;
    (s_sda_oe || m_sda_oe || m_scl_oe) |-> !(s_sda_o || m_sda_o || m_scl_o) &&
      (!s_sda_oe || !first_q || cnt_q == 4'h8);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("driver pushed a line high or slave spoke unasked");
  property p_oe_low_phase;
    $changed(s_sda_oe) |-> !scl && !scl_q;
  endproperty
  a_oe_low_phase: assert property (p_oe_low_phase)
    else $error("slave data moved while clock high");
  property p_hold_high;
    rise && s_sda_oe |-> s_sda_oe [*8] ##7 s_sda_oe;
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("slave low level not held over clock high");
  property p_foreign;
    s_ninth and (first_q && sh_q[7:1] != aid_pkg::SLAVE_ADDR) |-> !s_sda_oe;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("slave acknowledged a foreign address");
  property p_write_quiet;
    rise && cnt_q != 4'h8 && (first_q || !addr_q[0]) |-> !s_sda_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("slave drove data outside its acknowledge slot");
  property p_read_ack_free;
    s_ninth and (!first_q && addr_q[0]) |-> !s_sda_oe;
  endproperty
  a_read_ack_free: assert property (p_read_ack_free)
    else $error("slave drove the master acknowledge slot");
  property p_nack_release;
    s_ninth and (!first_q && addr_q[0] && sda) |-> ##20 !s_sda_oe [*8];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("slave kept sending after not-acknowledge");
  property p_stop_idle;
    s_stop |-> !s_sda_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("slave drove data after stop");
  property p_start_quiet;
    s_start |-> !s_sda_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("slave drove data during start");
endmodule

// *** testbench.sv ***
// Self-checking bench: controller and ID slave joined over the two-wire link
`timescale 1ns/100ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic sink_hotplug_in_i = 1'b0;
  logic hotplug_invert_strap_i = 1'b0;
  logic id_enable_strap_i = 1'b1;
  logic [1:0] mode_i = 2'h0;
  logic source_hotplug_out_o;
  logic main_link_en_o;
  logic ddc_active_o;
  int errors = 0;
  int check_count = 0;
  logic [31:0] st;

  always #5 ref_clk_i = ~ref_clk_i;

  aid_if i_aid_if ();
  aid_master #(.QTR_CYCLES(8)) i_aid_master (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .bus(i_aid_if), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  aid_slave i_aid_slave (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(i_aid_if),
    .sink_hotplug_in_i(sink_hotplug_in_i), .hotplug_invert_strap_i(hotplug_invert_strap_i),
    .id_enable_strap_i(id_enable_strap_i), .mode_i(mode_i),
    .source_hotplug_out_o(source_hotplug_out_o), .main_link_en_o(main_link_en_o),
    .ddc_active_o(ddc_active_o));
  aid_properties i_aid_properties (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .m_scl_o(i_aid_if.m_scl_o), .m_scl_oe(i_aid_if.m_scl_oe), .m_sda_o(i_aid_if.m_sda_o),
    .m_sda_oe(i_aid_if.m_sda_oe), .s_sda_o(i_aid_if.s_sda_o), .s_sda_oe(i_aid_if.s_sda_oe),
    .scl(i_aid_if.scl), .sda(i_aid_if.sda));

  task automatic close_out();
    $display("Mismatches %0d of %0d checks", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Expected memory contents kept apart from the design's own table
  function automatic logic [7:0] exp_byte(input int loc);
    string ph;
    ph = "DP-HDMI ADAPTOR";
    if (loc < 15) begin
      return ph[loc];
    end
    return (loc == 15) ? aid_pkg::EOT_CODE : aid_pkg::FILL_BYTE;
  endfunction

  task automatic cmd(input logic [2:0] c, input logic [7:0] b, input logic nk);
    int n;
    @(posedge ref_clk_i);
    reg_addr_i <= aid_pkg::REG_CMD;
    reg_wdata_i <= {20'h0, nk, c, b};
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    n = 0;
    st = 32'h1;
    // Busy is polled, never assumed from a fixed wait
    while (st[aid_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 400) begin
      @(posedge ref_clk_i);
      reg_addr_i <= aid_pkg::REG_STAT;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 st = reg_rdata_o;
      n++;
    end
    if (n >= 400) begin
      errors++;
      $display("[ERR] %0t busy stuck %h %h", $time, st, 32'h0);
      close_out();
    end
  endtask

  task automatic wbyte(input logic [7:0] b, input logic ea);
    cmd(aid_pkg::CMD_WRITE, b, 1'b0);
    chk(8'(st[aid_pkg::STAT_ACK_BIT]), 8'(ea));
  endtask

  task automatic probe(input logic [7:0] a, input logic ea);
    cmd(aid_pkg::CMD_START, 8'h00, 1'b0);
    wbyte(a, ea);
    cmd(aid_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic t_hotplug();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk_i);
      mode_i <= i[3:2];
      hotplug_invert_strap_i <= i[1];
      sink_hotplug_in_i <= i[0];
      repeat (6) @(posedge ref_clk_i);
      chk(8'(source_hotplug_out_o), 8'(i[0] ^ i[1]));
      chk(8'(main_link_en_o), 8'(i[3:2] == 2'h0));
      chk(8'(ddc_active_o), 8'(i[3:2] < 2'h2));
    end
    @(posedge ref_clk_i);
    mode_i <= aid_pkg::MODE_ACTIVE;
  endtask

  task automatic t_addr();
    probe(8'h82, 1'b0);
    probe(8'hc0, 1'b0);
    probe(8'h80, 1'b1);
  endtask

  task automatic t_strap();
    int i;
    // Straps move only while the bus is idle; mid-transfer aborts are untested
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk_i);
      id_enable_strap_i <= (i != 0);
      mode_i <= (i == 0) ? 2'h0 : 2'(i);
      repeat (4) @(posedge ref_clk_i);
      probe(8'h80, i == 1 || i == 4);
    end
    @(posedge ref_clk_i);
    mode_i <= aid_pkg::MODE_ACTIVE;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic t_port();
    // Unknown code leaves the bus alone; strobes while busy are dropped
    cmd(3'h7, 8'h00, 1'b0);
    chk(8'({i_aid_if.scl, i_aid_if.sda}), 8'h03);
    @(posedge ref_clk_i);
    reg_addr_i <= aid_pkg::REG_CMD;
    reg_wdata_i <= {20'h0, 1'b0, aid_pkg::CMD_START, 8'h00};
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wdata_i <= {20'h0, 1'b0, aid_pkg::CMD_STOP, 8'h00};
    cmd(3'h7, 8'h00, 1'b0);
    chk(8'({i_aid_if.scl, i_aid_if.sda}), 8'h00);
    cmd(aid_pkg::CMD_STOP, 8'h00, 1'b0);
    chk(8'({i_aid_if.scl, i_aid_if.sda}), 8'h03);
  endtask

  task automatic t_read(input logic [7:0] p, input int n, input bit pre);
    int i;
    if (pre) begin
      cmd(aid_pkg::CMD_START, 8'h00, 1'b0);
      wbyte(8'h80, 1'b1);
      wbyte(p, 1'b1);
      wbyte(8'h55, 1'b1);
      cmd(aid_pkg::CMD_STOP, 8'h00, 1'b0);
    end
    cmd(aid_pkg::CMD_START, 8'h00, 1'b0);
    wbyte(8'h81, 1'b1);
    for (i = 0; i < n; i++) begin
      cmd(aid_pkg::CMD_READ, 8'h00, i == n - 1);
      chk(st[aid_pkg::STAT_RX_LSB +: 8], exp_byte(p + i));
    end
    cmd(aid_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_hotplug();
    t_addr();
    t_port();
    t_strap();
    t_read(8'h00, 19, 1'b1);
    t_read(8'h0e, 4, 1'b1);
    t_read(8'h00, 2, 1'b0);
    close_out();
  end
endmodule
